// [common/adc_alarm_defines.vh]
// constants of the result-code path, the channel alarms and the apb register map
// assumes a 32-bit apb slave on pclk, 12-bit straight-binary conversion results
`ifndef ADC_ALARM_DEFINES_VH
`define ADC_ALARM_DEFINES_VH

`define CODE_BITS        12
`define RESULT_FALL      5'h10
`define RANGE_COUNT      4'h9

// register byte offsets
`define OFS_ACTIVE       12'h000
`define OFS_TRIPPED      12'h004
`define OFS_INT_STATUS   12'h008
`define OFS_INT_MASK     12'h00c
`define OFS_LAST_RESULT  12'h010
`define OFS_RANGE        12'h014
`define OFS_LSB_INFO     12'h018
`define OFS_THRESH_BASE  12'h040

// threshold block word select within a channel
`define SEL_HIGH_T       2'h0
`define SEL_HIGH_H       2'h1
`define SEL_LOW_T        2'h2
`define SEL_LOW_H        2'h3

// reset values
`define RST_HIGH_T       12'hfff
`define RST_LOW_T        12'h000
`define RST_HYST         12'h000
`define RST_RANGE        32'h0000_0000
`define RST_INT_MASK     2'h0

// interrupt status bits
`define INT_CONV         0
`define INT_TRIP         1

// lsb size in units of 1/16 mv at a 4.096 v reference
`define LSB_AUX          8'h10

`endif

// [src/alarm_channel.v]
// one channel's high and low alarm with thresholds, hysteresis and flags
// assumes thresholds written on pclk, evaluation strobe one cycle per conversion
`default_nettype none
`include "adc_alarm_defines.vh"

module alarm_channel (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // threshold write
  input  wire        wr_en,
  input  wire [1:0]  wr_sel,
  input  wire [11:0] wr_data,
  // conversion result
  input  wire        eval,
  input  wire [11:0] code,
  // tripped flag clear
  input  wire        trip_clear,
  // state
  output reg  [11:0] high_t,
  output reg  [11:0] high_h,
  output reg  [11:0] low_t,
  output reg  [11:0] low_h,
  output reg         high_active,
  output reg         low_active,
  output reg         high_tripped,
  output reg         low_tripped,
  output wire        trip_event
);

  // ------------------------------------------------------------
  // limits, 14-bit signed so nothing wraps
  // ------------------------------------------------------------
  wire signed [13:0] c      = {2'b00, code};
  wire signed [13:0] hi_set = {2'b00, high_t} + {2'b00, high_h};
  wire signed [13:0] hi_clr = {2'b00, high_t} - {2'b00, high_h} - 14'sd2;
  wire signed [13:0] lo_set = {2'b00, low_t} - {2'b00, low_h} - 14'sd1;
  wire signed [13:0] lo_clr = {2'b00, low_t} + {2'b00, low_h} + 14'sd1;

  wire hi_on  = eval && (c > hi_set);
  wire hi_off = eval && (c <= hi_clr);
  wire lo_on  = eval && (c < lo_set);
  wire lo_off = eval && (c >= lo_clr);

  assign trip_event = hi_on | lo_on;

  // ------------------------------------------------------------
  // thresholds and hysteresis
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_t <= `RST_HIGH_T;
      high_h <= `RST_HYST;
      low_t  <= `RST_LOW_T;
      low_h  <= `RST_HYST;
    end else if (wr_en) begin
      case (wr_sel)
        `SEL_HIGH_T: high_t <= wr_data;
        `SEL_HIGH_H: high_h <= wr_data;
        `SEL_LOW_T:  low_t  <= wr_data;
        default:     low_h  <= wr_data;
      endcase
    end
  end

  // ------------------------------------------------------------
  // active and tripped flags
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_active  <= 1'b0;
      low_active   <= 1'b0;
      high_tripped <= 1'b0;
      low_tripped  <= 1'b0;
    end else begin
      if (hi_on)
        high_active <= 1'b1;
      else if (hi_off)
        high_active <= 1'b0;
      if (lo_on)
        low_active <= 1'b1;
      else if (lo_off)
        low_active <= 1'b0;
      // set wins over the read clear
      if (hi_on)
        high_tripped <= 1'b1;
      else if (trip_clear)
        high_tripped <= 1'b0;
      if (lo_on)
        low_tripped <= 1'b1;
      else if (trip_clear)
        low_tripped <= 1'b0;
    end
  end

endmodule // alarm_channel

`default_nettype wire

// [src/result_shifter.v]
// msb-first shifter for the serial result output
// assumes load and shift strobes are single pclk cycles from synchronised edges
`default_nettype none
`include "adc_alarm_defines.vh"

module result_shifter #(
  parameter WIDTH = `CODE_BITS
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // control
  input  wire             load,
  input  wire             shift,
  input  wire             idle,
  input  wire [WIDTH-1:0] data,
  // serial bit
  output reg              bit_out
);

  reg [WIDTH-2:0] rest;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_out <= 1'b0;
      rest    <= {(WIDTH-1){1'b0}};
    end else if (idle) begin
      bit_out <= 1'b0;
      rest    <= {(WIDTH-1){1'b0}};
    end else if (load) begin
      bit_out <= data[WIDTH-1];
      rest    <= data[WIDTH-2:0];
    end else if (shift) begin
      // zeros follow the last bit
      bit_out <= rest[WIDTH-2];
      rest    <= {rest[WIDTH-3:0], 1'b0};
    end
  end

endmodule // result_shifter

`default_nettype wire

// [src/adc_code_alarm.v]
// result-code path, per-channel alarms, alarm pin and serial result output
// assumes apb master on pclk; cs_n and sclk pins asynchronous to pclk;
// the converter hands over straight-binary codes one pclk strobe per conversion
`default_nettype none
`include "adc_alarm_defines.vh"

module adc_code_alarm #(
  parameter NUM_CH = 8
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // converter result
  input  wire        conv_valid,
  input  wire [3:0]  conv_channel,
  input  wire [11:0] conv_code,
  // serial pins
  input  wire        cs_n,
  input  wire        sclk,
  output wire        serial_result_out,
  output reg         serial_result_oe,
  output reg         alarm,
  // interrupt
  output reg         irq
);

  // ------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------
  reg cs_m;
  reg cs_s;
  reg cs_d;
  reg sclk_m;
  reg sclk_s;
  reg sclk_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_m   <= 1'b1;
      cs_s   <= 1'b1;
      cs_d   <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      cs_m   <= cs_n;
      cs_s   <= cs_m;
      cs_d   <= cs_s;
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
    end
  end

  wire frame_start = cs_d & ~cs_s;
  wire in_frame    = ~cs_s;
  wire sclk_fall   = in_frame & sclk_d & ~sclk_s;

  // ------------------------------------------------------------
  // serial clock fall counter within a frame
  // ------------------------------------------------------------
  reg  [4:0] fall_count;
  wire       tap_fall  = sclk_fall && (fall_count == (`RESULT_FALL - 5'h01));
  wire       late_fall = sclk_fall && (fall_count == `RESULT_FALL);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fall_count <= 5'h00;
    else if (frame_start || !in_frame)
      fall_count <= 5'h00;
    else if (sclk_fall && fall_count != `RESULT_FALL)
      fall_count <= fall_count + 5'h01;
  end

  // ------------------------------------------------------------
  // last conversion result
  // ------------------------------------------------------------
  reg [11:0] last_code;
  reg [3:0]  last_channel;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_code    <= 12'h000;
      last_channel <= 4'h0;
    end else if (conv_valid) begin
      // straight binary: code 0 is negative full scale on bipolar ranges, top code positive
      last_code    <= conv_code;
      last_channel <= conv_channel;
    end
  end

  // ------------------------------------------------------------
  // serial result output
  // ------------------------------------------------------------
  result_shifter #(
    .WIDTH (`CODE_BITS)
  ) u_shift (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (tap_fall),
    .shift   (late_fall),
    .idle    (!in_frame),
    .data    (last_code),
    .bit_out (serial_result_out)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      serial_result_oe <= 1'b0;
    else
      serial_result_oe <= in_frame;
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire        access   = psel & penable;
  wire        done     = access & pready;
  wire        wr_done  = done & pwrite;
  wire        rd_done  = done & ~pwrite;
  wire        in_thr   = (paddr >= `OFS_THRESH_BASE) &&
                         (paddr < `OFS_THRESH_BASE + NUM_CH * 16);
  wire [11:0] thr_off  = paddr - `OFS_THRESH_BASE;
  wire [3:0]  thr_ch   = thr_off[7:4];
  wire [1:0]  thr_sel  = thr_off[3:2];

  // ------------------------------------------------------------
  // channel alarms
  // ------------------------------------------------------------
  wire [NUM_CH-1:0] high_active;
  wire [NUM_CH-1:0] low_active;
  wire [NUM_CH-1:0] high_tripped;
  wire [NUM_CH-1:0] low_tripped;
  wire [NUM_CH-1:0] trip_event;
  wire [12*NUM_CH-1:0] high_t;
  wire [12*NUM_CH-1:0] high_h;
  wire [12*NUM_CH-1:0] low_t;
  wire [12*NUM_CH-1:0] low_h;
  wire trip_read = access && !pready && !pwrite && (paddr == `OFS_TRIPPED);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      alarm_channel u_ch (
        .pclk         (pclk),
        .presetn      (presetn),
        .wr_en        (wr_done && in_thr && thr_ch == g),
        .wr_sel       (thr_sel),
        .wr_data      (pwdata[11:0]),
        .eval         (conv_valid && conv_channel == g),
        .code         (conv_code),
        .trip_clear   (trip_read),
        .high_t       (high_t[12*g +: 12]),
        .high_h       (high_h[12*g +: 12]),
        .low_t        (low_t[12*g +: 12]),
        .low_h        (low_h[12*g +: 12]),
        .high_active  (high_active[g]),
        .low_active   (low_active[g]),
        .high_tripped (high_tripped[g]),
        .low_tripped  (low_tripped[g]),
        .trip_event   (trip_event[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // alarm pin, updated on the 16th fall only
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      alarm <= 1'b0;
    else if (tap_fall)
      alarm <= |{high_tripped, low_tripped};
  end

  // ------------------------------------------------------------
  // input ranges and lsb size
  // ------------------------------------------------------------
  reg  [31:0] range_sel;
  reg  [3:0]  last_range;
  reg  [7:0]  last_lsb;
  reg         last_unipolar;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      range_sel <= `RST_RANGE;
    else if (wr_done && paddr == `OFS_RANGE)
      range_sel <= pwdata;
  end

  always @* begin
    last_range = (last_channel < NUM_CH) ? range_sel[4*last_channel[2:0] +: 4] : 4'h0;
    last_unipolar = 1'b0;
    last_lsb = 8'h00;
    if (last_channel >= NUM_CH) begin
      // auxiliary input: zero to reference only
      last_lsb      = `LSB_AUX;
      last_unipolar = 1'b1;
    end else begin
      case (last_range)
        4'h0:    last_lsb = 8'h50;
        4'h1:    last_lsb = 8'h28;
        4'h2:    last_lsb = 8'h14;
        4'h3:    last_lsb = 8'h0a;
        4'h4:    last_lsb = 8'h05;
        4'h5:    last_lsb = 8'h28;
        4'h6:    last_lsb = 8'h14;
        4'h7:    last_lsb = 8'h0a;
        4'h8:    last_lsb = 8'h05;
        default: last_lsb = 8'h00;
      endcase
      last_unipolar = (last_range >= 4'h5) && (last_range < `RANGE_COUNT);
    end
  end

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  reg [1:0] int_status;
  reg [1:0] int_mask;
  wire [1:0] int_set = {|trip_event, conv_valid};
  wire [1:0] int_clr = (wr_done && paddr == `OFS_INT_STATUS) ? pwdata[1:0] : 2'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= 2'h0;
      int_mask   <= `RST_INT_MASK;
      irq        <= 1'b0;
    end else begin
      int_status <= int_set | (int_status & ~int_clr);
      if (wr_done && paddr == `OFS_INT_MASK)
        int_mask <= pwdata[1:0];
      irq <= |(int_status & int_mask);
    end
  end

  // ------------------------------------------------------------
  // apb read data, one wait state
  // ------------------------------------------------------------
  reg [31:0] next_prdata;
  reg        next_err;

  always @* begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (in_thr) begin
      case (thr_sel)
        `SEL_HIGH_T: next_prdata = {20'h00000, high_t[12*thr_ch[2:0] +: 12]};
        `SEL_HIGH_H: next_prdata = {20'h00000, high_h[12*thr_ch[2:0] +: 12]};
        `SEL_LOW_T:  next_prdata = {20'h00000, low_t[12*thr_ch[2:0] +: 12]};
        default:     next_prdata = {20'h00000, low_h[12*thr_ch[2:0] +: 12]};
      endcase
    end else begin
      case (paddr)
        `OFS_ACTIVE:      next_prdata = {16'h0000, low_active, high_active};
        `OFS_TRIPPED:     next_prdata = {16'h0000, low_tripped, high_tripped};
        `OFS_INT_STATUS:  next_prdata = {30'h0, int_status};
        `OFS_INT_MASK:    next_prdata = {30'h0, int_mask};
        `OFS_LAST_RESULT: next_prdata = {16'h0000, last_channel, last_code};
        `OFS_RANGE:       next_prdata = range_sel;
        `OFS_LSB_INFO:    next_prdata = {19'h00000, last_unipolar, last_range, last_lsb};
        default:          next_err    = 1'b1;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      prdata  <= (access & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= access & ~pready & next_err;
    end
  end

endmodule // adc_code_alarm

`default_nettype wire

// [verification/adc_alarm_props.sv]
// checker on the apb answer, serial pins and alarm pin; the interrupt output is connected but not checked
// assumes it is bound to adc_code_alarm and sees only that module's ports
`default_nettype none

module adc_alarm_props #(
  parameter NUM_CH = 8
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // converter
  input wire logic        conv_valid,
  input wire logic [3:0]  conv_channel,
  input wire logic [11:0] conv_code,
  // serial pins and outputs
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        serial_result_out,
  input wire logic        serial_result_oe,
  input wire logic        alarm,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_open;
    $fell(cs_n);
  endsequence
  sequence s_cs_idle;
    cs_n [*4];
  endsequence

  AST_PREADY_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not in second access cycle");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready || pwrite |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside a read");
  AST_OE_OPEN: assert property (s_open |-> ##[1:4] serial_result_oe)
    else $error("serial output not enabled in frame");
  AST_OUT_IDLE: assert property (s_cs_idle |-> !serial_result_oe && !serial_result_out)
    else $error("serial output active outside frame");
  AST_ALARM_FRAME: assert property ($changed(alarm) |-> !$past(cs_n, 2))
    else $error("alarm changed outside a frame");
  AST_ALARM_HOLD: assert property (s_cs_idle |=> $stable(alarm))
    else $error("alarm changed while frame idle");

  COV_FRAME: cover property (s_open ##[1:4] serial_result_oe);
endmodule // adc_alarm_props

bind adc_code_alarm adc_alarm_props #(.NUM_CH(NUM_CH)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_code(conv_code),
  .cs_n(cs_n), .sclk(sclk), .serial_result_out(serial_result_out),
  .serial_result_oe(serial_result_oe), .alarm(alarm), .irq(irq)
);
`default_nettype wire

// [verification/spi_host_model.sv]
// host on the serial pins: frames of 28 sclk falls, result read msb first
// assumes the device launches each bit on a fall; sclk stands high between frames;
// nothing pulls the data line, so a released line reads as the inverse
`default_nettype none

module spi_host_model (
  // serial pins
  output var logic  cs_n,
  output var logic  sclk,
  input  wire logic serial_result_out,
  input  wire logic serial_result_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  wire logic line_seen = serial_result_oe ? serial_result_out : ~serial_result_out;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end

  // one frame; bits are taken just before falls 17..28
  task automatic frame(output logic [11:0] word);
    int k;
    word = 12'h000;
    #7 cs_n = 1'b0;
    #16;
    for (k = 1; k <= 28; k++) begin
      #16;
      if (k >= 17) word = {word[10:0], line_seen};
      sclk = 1'b0;
      #16 sclk = 1'b1;
    end
    #16 cs_n = 1'b1;
    #40;
  endtask
endmodule // spi_host_model
`default_nettype wire

// [verification/tb_adc_code_alarm.sv]
// bench for adc_code_alarm: apb tasks, converter strobes, serial frames
// assumes spi_host_model on the serial pins and the bound checker
`default_nettype none
`include "adc_alarm_defines.vh"

module tb_adc_code_alarm;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        conv_valid = 1'b0;
  logic [3:0]  conv_channel = 4'h0;
  logic [11:0] conv_code = 12'h000;
  wire  [31:0] prdata;
  wire         pready, pslverr, cs_n, sclk, serial_result_out, serial_result_oe;
  wire         alarm, irq;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [31:0] rd;
  logic        err;
  logic [11:0] word;
  localparam logic [11:0] B = `OFS_THRESH_BASE;

  always #2 pclk = ~pclk;

  adc_code_alarm #(.NUM_CH(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_code(conv_code),
    .cs_n(cs_n), .sclk(sclk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .alarm(alarm), .irq(irq)
  );
  spi_host_model i_host (.cs_n(cs_n), .sclk(sclk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  task automatic conv(input logic [3:0] ch, input logic [11:0] c);
    @(posedge pclk);
    conv_valid <= 1'b1;
    conv_channel <= ch;
    conv_code <= c;
    @(posedge pclk);
    conv_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk("high_t", B, 32'h0000_0fff);
    rdchk("low_t", B + 12'h008, 32'h0000_0000);
    rdchk("mask", `OFS_INT_MASK, 32'h0000_0000);
    apb(1'b0, 12'h03c, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, err});
    chk("bad_rdata", 32'h0, rd);
  endtask
  task automatic t_high;
    wr(B, 32'h0000_0064);
    wr(B + 12'h004, 32'h0000_0005);
    conv(4'h0, 12'h069);
    rdchk("act_105", `OFS_ACTIVE, 32'h0);
    conv(4'h0, 12'h06a);
    rdchk("act_106", `OFS_ACTIVE, 32'h1);
    conv(4'h2, 12'h000);
    conv(4'h8, 12'h000);
    rdchk("act_other", `OFS_ACTIVE, 32'h1);
    conv(4'h0, 12'h05e);
    rdchk("act_94", `OFS_ACTIVE, 32'h1);
    conv(4'h0, 12'h05d);
    rdchk("act_93", `OFS_ACTIVE, 32'h0);
    chk("alarm_no_frame", 32'h0, {31'h0, alarm});
  endtask
  task automatic t_low;
    wr(B + 12'h018, 32'h0000_0032);
    wr(B + 12'h01c, 32'h0000_0003);
    conv(4'h1, 12'h02e);
    rdchk("act_46", `OFS_ACTIVE, 32'h0);
    conv(4'h1, 12'h02d);
    rdchk("act_45", `OFS_ACTIVE, 32'h200);
    conv(4'h1, 12'h035);
    rdchk("act_53", `OFS_ACTIVE, 32'h200);
    conv(4'h1, 12'h036);
    rdchk("act_54", `OFS_ACTIVE, 32'h0);
  endtask
  task automatic t_frame;
    conv(4'h3, 12'ha5c);
    i_host.frame(word);
    chk("result", 32'h0000_0a5c, {20'h0, word});
    rdchk("last", `OFS_LAST_RESULT, 32'h0000_3a5c);
    chk("alarm_set", 32'h1, {31'h0, alarm});
  endtask
  task automatic t_irq;
    rdchk("status", `OFS_INT_STATUS, 32'h3);
    wr(`OFS_INT_MASK, 32'h2);
    irq_is(1'b1);
    wr(`OFS_INT_STATUS, 32'h2);
    irq_is(1'b0);
    rdchk("status_w1c", `OFS_INT_STATUS, 32'h1);
    wr(`OFS_INT_MASK, 32'h1);
    irq_is(1'b1);
    wr(`OFS_INT_MASK, 32'h0);
    irq_is(1'b0);
  endtask
  task automatic t_trip;
    chk("alarm_seen", 32'h1, {31'h0, alarm});
    rdchk("tripped", `OFS_TRIPPED, 32'h201);
    rdchk("tripped_clr", `OFS_TRIPPED, 32'h0);
    i_host.frame(word);
    chk("alarm_clr", 32'h0, {31'h0, alarm});
  endtask
  task automatic t_range;
    int r;
    logic [3:0] ch;
    logic [7:0] lsb;
    logic uni;
    rdchk("range_rst", `OFS_RANGE, 32'h0000_0000);
    wr(`OFS_RANGE, 32'h7654_3210);
    for (r = 0; r < 10; r++) begin
      if (r == 8) wr(`OFS_RANGE, 32'h0000_0098);
      ch = (r < 8) ? r[3:0] : r[3:0] - 4'h8;
      // span halves per step within ranges 0..4 and within 5..8: 80/16 mv at the widest bipolar range
      lsb = (r < 5) ? (8'h50 >> r) : (r < 9) ? (8'h50 >> (r - 4)) : 8'h00;
      uni = (r >= 5) && (r <= 8);
      conv(ch, 12'h050);
      rdchk("lsb_info", `OFS_LSB_INFO, {19'h0, uni, r[3:0], lsb});
    end
    conv(4'h8, 12'h050);
    rdchk("lsb_aux", `OFS_LSB_INFO, 32'h0000_1010);
  endtask

  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_high();
    t_low();
    t_frame();
    t_irq();
    t_trip();
    t_range();
    end_of_test();
  end

  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule // tb_adc_code_alarm
`default_nettype wire
